// *** design/diag_adc_pkg.sv ***
// Constants, types and code decoding for the diagnostic converter request queue.
// Assumes one system clock; the link pins are sampled by that clock.
// Notes on behaviour
// R1: Four independent request slots, A to D
// R2: Request code bits 6:0, reply flag bit 19
// R3: Master sends one command per slot, any order
// R4: Master programs slow inputs before requesting
// R5: Low ready bit is fresh A or B
// R6: High ready bit is fresh C or D
// R7: Fresh set on completion, cleared on read
// R8: Result changes only on newer result
// R9: Requests during conversion wait pending
// R10: Pending conversions run first in first out
// R11: Queue holds four entries
// R12: Repeated slot request replaces pending code
// R13: Result lands only in requesting slot, except R20 pair
// R14: Codes 3, 4, 5 select sensor V, I, R
// R15: Codes 11 to 14 select sensor voltages
// R16: Codes 6, 7, 8, 10 select loop, bandgap, temp
// R17: Codes 32 to 43 supplies, 37 unused
// R18: Codes 44 to 47 driver drain/source voltages
// R19: Codes 50, 51 select remote sensor voltages
// R20: Resistance via slot A, results A and B
// R21: Unused codes accepted, result undefined
package diag_adc_pkg;

  localparam int CODE_W     = 7;
  localparam int RESULT_W   = 10;
  localparam int ADDR_W     = 7;
  localparam int FRAME_W    = 32;
  localparam int SLOT_COUNT = 4;

  localparam logic [5:0]        FRAME_BITS = 6'h20;
  localparam int                ADDR_LSB   = 24;
  localparam int                FRESH_BIT  = 19;
  localparam int                CODE_LSB   = 10;

  localparam logic [ADDR_W-1:0] DIAG_SLOT_A_COMMAND = 7'h3A;
  localparam logic [ADDR_W-1:0] DIAG_SLOT_B_COMMAND = 7'h3B;
  localparam logic [ADDR_W-1:0] DIAG_SLOT_C_COMMAND = 7'h3C;
  localparam logic [ADDR_W-1:0] DIAG_SLOT_D_COMMAND = 7'h3D;
  localparam logic [ADDR_W-1:0] GLOBAL_STATUS_WORD  = 7'h7F;

  localparam logic [CODE_W-1:0]   CODE_RESET   = 7'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [FRAME_W-1:0]  REPLY_RESET  = 32'h0000_0000;

  localparam logic [CODE_W-1:0] CODE_DCS_SEL_V     = 7'h03;
  localparam logic [CODE_W-1:0] CODE_DCS_SEL_I     = 7'h04;
  localparam logic [CODE_W-1:0] CODE_DCS_SEL_R     = 7'h05;
  localparam logic [CODE_W-1:0] CODE_SQUIB_LOOP    = 7'h06;
  localparam logic [CODE_W-1:0] CODE_BANDGAP_REF   = 7'h07;
  localparam logic [CODE_W-1:0] CODE_BANDGAP_MON   = 7'h08;
  localparam logic [CODE_W-1:0] CODE_TEMPERATURE   = 7'h0A;
  localparam logic [CODE_W-1:0] CODE_DCS_CH0_V     = 7'h0B;
  localparam logic [CODE_W-1:0] CODE_DCS_CH3_V     = 7'h0E;
  localparam logic [CODE_W-1:0] CODE_SUPPLY_FIRST  = 7'h20;
  localparam logic [CODE_W-1:0] CODE_SUPPLY_UNUSED = 7'h25;
  localparam logic [CODE_W-1:0] CODE_SUPPLY_LAST   = 7'h2B;
  localparam logic [CODE_W-1:0] CODE_DRIVER_FIRST  = 7'h2C;
  localparam logic [CODE_W-1:0] CODE_DRIVER_LAST   = 7'h2F;
  localparam logic [CODE_W-1:0] CODE_REMOTE_CH0_V  = 7'h32;
  localparam logic [CODE_W-1:0] CODE_REMOTE_CH1_V  = 7'h33;

  typedef enum logic [0:0] {CONV_IDLE, CONV_BUSY} conv_state_t;

  // True for every code that selects a defined measurement
  function automatic logic code_is_used(input logic [CODE_W-1:0] code);
    logic used;
    used = 1'b0;
    if (code >= CODE_DCS_SEL_V && code <= CODE_BANDGAP_MON) used = 1'b1;                    // R14 R16
    if (code >= CODE_TEMPERATURE && code <= CODE_DCS_CH3_V) used = 1'b1;                    // R15 R16
    if (code >= CODE_SUPPLY_FIRST && code <= CODE_SUPPLY_LAST && code != CODE_SUPPLY_UNUSED) used = 1'b1; // R17
    if (code >= CODE_DRIVER_FIRST && code <= CODE_DRIVER_LAST) used = 1'b1;                 // R18
    if (code == CODE_REMOTE_CH0_V || code == CODE_REMOTE_CH1_V) used = 1'b1;                // R19
    return used;
  endfunction

  // Slot index decoded from a command address
  function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - DIAG_SLOT_A_COMMAND;
    return diff[1:0];
  endfunction

endpackage

// *** design/pin_filter.sv ***
// Three-stage sampler for pins from outside the system clock domain.
// Assumes the pins are quasi-static relative to the system clock period.
`timescale 1ns/1ps
module pin_filter #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } filt_state_t;

  filt_state_t filt_reg;
  filt_state_t filt_next;

  always_comb begin
    filt_next    = filt_reg;
    filt_next.s1 = pin_i;
    filt_next.s2 = filt_reg.s1;
    filt_next.s3 = filt_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (filt_reg.s2[i] == filt_reg.s3[i]) begin
        filt_next.level[i] = filt_reg.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      filt_reg <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, level: RESET_VAL};
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign level_o = filt_reg.level;

endmodule // pin_filter

// *** design/diag_adc_request_queue.sv ***
// Request queue and result store for the diagnostic converter, with its serial command port.
// Assumes a mode 0 serial master with 32-bit frames and a converter on the system clock.
`timescale 1ns/1ps
module diag_adc_request_queue
  import diag_adc_pkg::*;
#(
  parameter int QUEUE_DEPTH = 4
) (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                mosi_i,
  output logic                     miso_o,
  output logic                     miso_oe_o,
  output logic                     conv_start_o,
  output logic [CODE_W-1:0]        conv_code_o,
  output logic                     conv_code_used_o,
  output logic                     conv_pair_o,
  input  wire logic                conv_done_i,
  input  wire logic [RESULT_W-1:0] conv_result_i,
  input  wire logic [RESULT_W-1:0] conv_aux_i,
  output logic [SLOT_COUNT-1:0]    slot_result_fresh_o,
  output logic                     conv_ready_low_pair_o,
  output logic                     conv_ready_high_pair_o,
  output logic [2:0]               queue_level_o
);

  typedef struct packed {
    conv_state_t                               st;
    logic [1:0]                                busy_slot;
    logic                                      busy_pair;
    logic                                      start;
    logic [CODE_W-1:0]                         conv_code;
    logic [QUEUE_DEPTH-1:0][1:0]               q_slot;
    logic [2:0]                                q_count;
    logic [SLOT_COUNT-1:0]                     pend;
    logic [SLOT_COUNT-1:0][CODE_W-1:0]         pend_code;
    logic [SLOT_COUNT-1:0][RESULT_W-1:0]       result;
    logic [SLOT_COUNT-1:0]                     fresh;
    logic                                      sclk_q;
    logic                                      cs_n_q;
    logic [FRAME_W-1:0]                        rx_sh;
    logic [FRAME_W-1:0]                        tx_sh;
    logic [5:0]                                bit_cnt;
    logic                                      miso;
  } queue_state_t;

  queue_state_t      q_reg;
  queue_state_t      q_next;
  logic              sclk_f;
  logic              cs_n_f;
  logic              mosi_f;
  logic              frame_end;
  logic              req_valid;
  logic [1:0]        req_slot;
  logic [CODE_W-1:0] req_code;
  logic [ADDR_W-1:0] frame_addr;
  logic              pop_now;

  // Serial pins sampled into the system clock domain
  pin_filter #(
    .WIDTH     (3),
    .RESET_VAL (3'h2)
  ) u_pin_filter (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .pin_i     ({sclk_i, cs_n_i, mosi_i}),
    .level_o   ({sclk_f, cs_n_f, mosi_f})
  );

  assign frame_end  = !q_reg.cs_n_q && cs_n_f && (q_reg.bit_cnt == FRAME_BITS);
  assign frame_addr = q_reg.rx_sh[ADDR_LSB +: ADDR_W];
  assign req_valid  = frame_end && (frame_addr >= DIAG_SLOT_A_COMMAND) && (frame_addr <= DIAG_SLOT_D_COMMAND); // R1
  assign req_slot   = slot_of(frame_addr);
  assign req_code   = q_reg.rx_sh[CODE_W-1:0];                                                     // R2
  assign pop_now    = (q_reg.st == CONV_IDLE) && (q_reg.q_count != 3'h0);

  always_comb begin
    logic [2:0] cnt;
    logic       dcs_pair;
    cnt      = 3'h0;
    dcs_pair = 1'b0;
    q_next        = q_reg;
    q_next.start  = 1'b0;
    q_next.sclk_q = sclk_f;
    q_next.cs_n_q = cs_n_f;

    // Serial shift engine
    if (q_reg.cs_n_q && !cs_n_f) begin
      q_next.bit_cnt = 6'h00;
      q_next.miso    = q_reg.tx_sh[FRAME_W-1];
    end else if (!cs_n_f && !q_reg.sclk_q && sclk_f) begin
      q_next.rx_sh = {q_reg.rx_sh[FRAME_W-2:0], mosi_f};
      if (q_reg.bit_cnt != 6'h3F) begin
        q_next.bit_cnt = q_reg.bit_cnt + 6'h01;
      end
    end else if (!cs_n_f && q_reg.sclk_q && !sclk_f) begin
      q_next.tx_sh = {q_reg.tx_sh[FRAME_W-2:0], 1'b0};
      q_next.miso  = q_reg.tx_sh[FRAME_W-2];
    end

    // Reply for the next frame; a slot reply reads the slot and clears its flag
    if (frame_end) begin
      q_next.tx_sh = REPLY_RESET;
      q_next.tx_sh[ADDR_LSB +: ADDR_W] = frame_addr;
      if (req_valid) begin
        q_next.tx_sh[FRESH_BIT]              = q_reg.fresh[req_slot];                                // R2
        q_next.tx_sh[CODE_LSB +: CODE_W]     = req_code;                                             // R2
        q_next.tx_sh[RESULT_W-1:0]           = q_reg.result[req_slot];                               // R8
        q_next.fresh[req_slot]               = 1'b0;                                                 // R7
      end else if (frame_addr == GLOBAL_STATUS_WORD) begin
        q_next.tx_sh[1:0] = {conv_ready_high_pair_o, conv_ready_low_pair_o};
      end
    end

    // Oldest pending request starts when the converter is free
    cnt = q_reg.q_count;
    if (pop_now) begin
      q_next.busy_slot = q_reg.q_slot[0];                                                            // R10
      q_next.conv_code = q_reg.pend_code[q_reg.q_slot[0]];
      q_next.busy_pair = (q_reg.q_slot[0] == 2'h0) && (q_reg.pend_code[0] == CODE_DCS_SEL_R);        // R20
      q_next.pend[q_reg.q_slot[0]] = 1'b0;
      q_next.start = 1'b1;
      q_next.st    = CONV_BUSY;
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
        q_next.q_slot[i] = q_reg.q_slot[i+1];                                                        // R10
      end
      cnt = q_reg.q_count - 3'h1;
    end

    // New request: replace a pending one in place, else join the tail
    if (req_valid) begin
      q_next.pend_code[req_slot] = req_code;                                                         // R12 R21
      if (!q_next.pend[req_slot] && cnt < 3'(QUEUE_DEPTH)) begin                                     // R11
        q_next.q_slot[cnt[1:0]] = req_slot;                                                          // R9
        q_next.pend[req_slot]   = 1'b1;
        cnt = cnt + 3'h1;
      end
    end
    q_next.q_count = cnt;

    // Completion writes only the requesting slot, or A and B for a resistance pair; set wins over a read clear
    if (q_reg.st == CONV_BUSY && conv_done_i) begin
      dcs_pair = q_reg.busy_pair;
      q_next.st = CONV_IDLE;
      if (dcs_pair) begin
        q_next.result[0] = conv_result_i;                                                            // R20
        q_next.result[1] = conv_aux_i;                                                               // R20
        q_next.fresh[1:0] = 2'h3;                                                                    // R7
      end else begin
        q_next.result[q_reg.busy_slot] = conv_result_i;                                              // R13
        q_next.fresh[q_reg.busy_slot]  = 1'b1;                                                       // R7
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q_reg <= '{st: CONV_IDLE, busy_slot: 2'h0, busy_pair: 1'b0, start: 1'b0, conv_code: CODE_RESET,
                 q_slot: '0, q_count: 3'h0, pend: '0, pend_code: '0, result: '0,
                 fresh: '0, sclk_q: 1'b0, cs_n_q: 1'b1, rx_sh: REPLY_RESET, tx_sh: REPLY_RESET,
                 bit_cnt: 6'h00, miso: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign miso_o                 = q_reg.miso;
  assign miso_oe_o              = !cs_n_f;
  assign conv_start_o           = q_reg.start;
  assign conv_code_o            = q_reg.conv_code;
  assign conv_code_used_o       = code_is_used(q_reg.conv_code);                                     // R21
  assign conv_pair_o            = q_reg.busy_pair;
  assign slot_result_fresh_o    = q_reg.fresh;
  assign conv_ready_low_pair_o  = q_reg.fresh[0] | q_reg.fresh[1];                                   // R5
  assign conv_ready_high_pair_o = q_reg.fresh[2] | q_reg.fresh[3];                                   // R6
  assign queue_level_o          = q_reg.q_count;

  a_ready_low_pair: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R5
    conv_ready_low_pair_o == (slot_result_fresh_o[1:0] != 2'h0))
    else $error("low ready bit differs from A or B flag");

  a_ready_high_pair: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R6
    conv_ready_high_pair_o == (slot_result_fresh_o[3:2] != 2'h0))
    else $error("high ready bit differs from C or D flag");

  a_fresh_on_done: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R7
    (q_reg.st == CONV_BUSY && conv_done_i) |=> slot_result_fresh_o[$past(q_reg.busy_slot)])
    else $error("fresh flag not set after completion");

  a_fresh_read_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R7
    (req_valid && !(q_reg.st == CONV_BUSY && conv_done_i)) |=> !slot_result_fresh_o[$past(req_slot)])
    else $error("fresh flag not cleared by read");

  a_result_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R8
    !(q_reg.st == CONV_BUSY && conv_done_i) |=> $stable(q_reg.result))
    else $error("result changed without a new conversion");

  a_busy_no_start: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R9
    (q_reg.st == CONV_BUSY && !conv_done_i) |=> !conv_start_o)
    else $error("conversion started while converter busy");

  a_fifo_head: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R10
    pop_now |=> conv_start_o && q_reg.busy_slot == $past(q_reg.q_slot[0]))
    else $error("started slot is not the queue head");

  a_queue_depth: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R11
    queue_level_o <= 3'(QUEUE_DEPTH))
    else $error("queue level above depth");

  a_replace_code: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R12
    (req_valid && q_reg.pend[req_slot] && !pop_now) |=>
      (queue_level_o == $past(queue_level_o)) && (q_reg.pend_code[$past(req_slot)] == $past(req_code)))
    else $error("repeated request not replaced in place");

  a_slot_target: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R13
    (q_reg.st == CONV_BUSY && conv_done_i && !q_reg.busy_pair) |=>
      q_reg.result[$past(q_reg.busy_slot)] == $past(conv_result_i))
    else $error("result stored in wrong slot");

  a_pair_split: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R20
    (q_reg.st == CONV_BUSY && conv_done_i && q_reg.busy_pair) |=>
      q_reg.result[1] == $past(conv_aux_i) && slot_result_fresh_o[1:0] == 2'h3)
    else $error("resistance voltage part not in slot B");

endmodule // diag_adc_request_queue

// *** verif/spi_master_model.sv ***
// Serial master model that posts converter requests and collects replies.
// Assumes mode 0 timing, paced by the 20 ns system clock for a 160 ns link clock.
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic sys_clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One 32-bit frame, MSB first; link clock stands low between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge sys_clk_i);
    cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = tx[i];
      repeat (4) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      rx[i] = miso_i;
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(negedge sys_clk_i);
  endtask
endmodule // spi_master_model

// *** verif/tb_top.sv ***
// Self-checking bench for the diagnostic converter request queue.
// Assumes the serial master model and a behavioural converter in this module.
`timescale 1ns/1ps
module tb_top
  import diag_adc_pkg::*;
;
  logic                sys_clk_i;
  logic                reset_i;
  logic                sclk, cs_n, mosi, miso, miso_oe;
  logic                conv_start, conv_used, conv_pair, conv_done;
  logic [CODE_W-1:0]   conv_code;
  logic [RESULT_W-1:0] conv_result, conv_aux;
  logic [3:0]          fresh;
  logic                rdy_low, rdy_high;
  logic [2:0]          level;
  logic [31:0]         rx;
  logic [CODE_W-1:0]   started[$];
  logic                busy_m = 1'b0;
  logic                chk_used = 1'b0;
  logic                pair_seen = 1'b0;
  int                  lat = 2;
  int                  cnt = 0;
  int                  failures = 0;
  int                  check_count = 0;

  spi_master_model master (.sys_clk_i(sys_clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  diag_adc_request_queue #(.QUEUE_DEPTH(4)) DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .conv_start_o(conv_start), .conv_code_o(conv_code),
    .conv_code_used_o(conv_used), .conv_pair_o(conv_pair), .conv_done_i(conv_done),
    .conv_result_i(conv_result), .conv_aux_i(conv_aux), .slot_result_fresh_o(fresh),
    .conv_ready_low_pair_o(rdy_low), .conv_ready_high_pair_o(rdy_high), .queue_level_o(level));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    conv_done = 1'b0;
    conv_result = '0;
    conv_aux = '0;
  end

  // Converter: each result carries its code, so a misrouted result shows
  always @(negedge sys_clk_i) begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1) begin
      started.push_back(conv_code);
      pair_seen <= conv_pair;
      conv_result <= {3'h5, conv_code};
      conv_aux <= {3'h2, conv_code};
      if (chk_used) check("code_used", exp_used(conv_code), conv_used);
      busy_m <= 1'b1;
      cnt <= lat;
    end else if (busy_m) begin
      if (cnt == 0) begin
        conv_done <= 1'b1;
        busy_m <= 1'b0;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end

  function automatic logic exp_used(input logic [CODE_W-1:0] c);
    return (c >= 7'h03 && c <= 7'h08) || (c >= 7'h0A && c <= 7'h0E) ||
           (c >= 7'h20 && c <= 7'h2F && c != 7'h25) || c == 7'h32 || c == 7'h33;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic send(input logic [ADDR_W-1:0] addr, input logic [CODE_W-1:0] code);
    master.xfer({1'b0, addr, 17'h00000, code}, rx);
  endtask

  task automatic chk_reply(input logic f, input logic [CODE_W-1:0] c, input logic [RESULT_W-1:0] r);
    check("reply_fresh", f, rx[FRESH_BIT]);
    check("reply_code", c, rx[CODE_LSB +: CODE_W]);
    check("reply_result", r, rx[RESULT_W-1:0]);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((level !== 3'h0 || busy_m || conv_start !== 1'b0) && n < 40000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 40000) begin
      failures++;
      test_done();
    end
    repeat (3) @(negedge sys_clk_i);
  endtask

  task automatic t_reset();
    check("fresh", 4'h0, fresh);
    check("queue_level", 3'h0, level);
    check("ready_pairs", 2'h0, {rdy_high, rdy_low});
    check("miso_oe", 1'b0, miso_oe);
    $display("test reset done");
  endtask

  task automatic t_queue();
    logic [CODE_W-1:0] exp_q [5];
    exp_q = '{7'h07, 7'h2D, 7'h32, 7'h0B, 7'h20};
    lat = 1500;
    started.delete();
    send(DIAG_SLOT_A_COMMAND, 7'h07);
    send(DIAG_SLOT_D_COMMAND, 7'h2C);
    send(DIAG_SLOT_B_COMMAND, 7'h32);
    send(DIAG_SLOT_C_COMMAND, 7'h0B);
    send(DIAG_SLOT_A_COMMAND, 7'h20);
    check("queue_level", 3'h4, level);
    send(DIAG_SLOT_D_COMMAND, 7'h2D);
    check("queue_level", 3'h4, level);
    wait_idle();
    check("start_count", 5, started.size());
    for (int i = 0; i < 5; i++) check("start_order", exp_q[i], started[i]);
    check("fresh", 4'hF, fresh);
    check("ready_pairs", 2'h3, {rdy_high, rdy_low});
    $display("test queue done");
  endtask

  task automatic t_read();
    send(DIAG_SLOT_A_COMMAND, 7'h03);
    check("fresh_a", 1'b0, fresh[0]);
    check("ready_low", 1'b1, rdy_low);
    send(DIAG_SLOT_B_COMMAND, 7'h04);
    chk_reply(1'b1, 7'h03, {3'h5, 7'h20});
    check("ready_low", 1'b0, rdy_low);
    send(DIAG_SLOT_A_COMMAND, 7'h03);
    chk_reply(1'b1, 7'h04, {3'h5, 7'h32});
    send(GLOBAL_STATUS_WORD, 7'h00);
    chk_reply(1'b0, 7'h03, {3'h5, 7'h20});
    send(GLOBAL_STATUS_WORD, 7'h00);
    check("status_ready", 2'h2, rx[1:0]);
    check("status_addr", GLOBAL_STATUS_WORD, rx[ADDR_LSB +: ADDR_W]);
    wait_idle();
    $display("test read done");
  endtask

  task automatic t_pair();
    lat = 20;
    send(DIAG_SLOT_A_COMMAND, CODE_DCS_SEL_R);
    wait_idle();
    check("pair", 1'b1, pair_seen);
    check("fresh_ab", 2'h3, fresh[1:0]);
    send(DIAG_SLOT_A_COMMAND, 7'h07);
    send(DIAG_SLOT_B_COMMAND, 7'h07);
    chk_reply(1'b1, 7'h07, {3'h5, 7'h05});
    send(GLOBAL_STATUS_WORD, 7'h00);
    chk_reply(1'b1, 7'h07, {3'h2, 7'h05});
    wait_idle();
    send(7'h10, 7'h07);
    check("refused_level", 3'h0, level);
    check("refused_start", 1'b0, busy_m);
    send(GLOBAL_STATUS_WORD, 7'h00);
    check("other_reply", {1'b0, 7'h10, 24'h000000}, rx);
    $display("test pair done");
  endtask

  task automatic t_codes();
    lat = 2;
    chk_used = 1'b1;
    for (int c = 0; c < 52; c++) begin
      if (c != 1 && c != 2) begin
        send(DIAG_SLOT_C_COMMAND, c[6:0]);
        wait_idle();
      end
    end
    chk_used = 1'b0;
    $display("test codes done");
  endtask

  initial begin
    reset_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    t_reset();
    t_queue();
    t_read();
    t_pair();
    t_codes();
    test_done();
  end
endmodule // tb_top
